//--- src/osc_config_defines.svh
// Purpose: offsets, field positions and reset values for the
//          oscillator configuration decoder
// Assumes: one register port with a 4-bit address, byte-wide data, 10 MHz system clock
// Notes: register offsets are local to this block
//
// Notes on behaviour
// - bit 7 enables dual-speed start-up
// - bit 6 enables fail-safe clock monitor
// - bits 5..3 always read as zero
// - bit 2 set, select 00: primary oscillator
// - bit 2 clear, select 00: internal RC
// - type 11: external clock, PLL, clock-out
// - type 10: external clock, clock-out, no PLL
// - type 01: high-speed crystal, PLL available
`ifndef OSC_CONFIG_DEFINES_SVH
`define OSC_CONFIG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OCD_ADDR_W 4
`define OCD_OFS_CLOCK_CONFIG_LOW 4'h0
`define OCD_OFS_RUNTIME_SELECT 4'h1
`define OCD_OFS_STATUS 4'h2

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define OCD_BIT_DUAL_SPEED 7
`define OCD_BIT_FAILSAFE 6
`define OCD_BIT_DEFAULT_SEL 2
`define OCD_IMPL_MASK 8'hC7
`define OCD_UNPROGRAMMED 8'hC7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OCD_RUNTIME_SELECT_RST 2'h0

`endif

//--- src/osc_config_pkg.sv
// Purpose: shared types of the oscillator configuration decoder
// Assumes: nothing beyond the defines header
// Notes: codes match the two-bit oscillator-type field
package osc_config_pkg;

  // ----------------------------------------------------------------
  // oscillator modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OSC_STD_CRYSTAL = 2'h0,
    OSC_HIGH_SPEED_CRYSTAL = 2'h1,
    OSC_EXTERNAL_CLOCK = 2'h2,
    OSC_EXTERNAL_CLOCK_PLL = 2'h3
  } osc_mode_t;

endpackage

//--- src/write_once_byte.sv
// Purpose: one write-once configuration byte held in flip-flops
// Assumes: reset models the erased, unprogrammed state
// Notes: unimplemented bits are constant zero
`timescale 1ns/1ns
`include "osc_config_defines.svh"
module write_once_byte
  import osc_config_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = `OCD_IMPL_MASK
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // programming port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  // stored value
  output logic [WIDTH-1:0] value,
  output logic programmed
);

  logic programmed_q;
  wire logic take = wr_en & ~programmed_q;

  // ----------------------------------------------------------------
  // per-bit storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    if (IMPL_MASK[i]) begin : g_impl
      logic bit_q;
      always_ff @(posedge clk) begin
        if (rst) begin
          bit_q <= 1'b1;
        end else if (take) begin
          bit_q <= wdata[i];
        end
      end
      assign value[i] = bit_q;
    end else begin : g_unimpl
      assign value[i] = 1'b0;
    end
  end

  // once taken, later writes are ignored without any sign on the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      programmed_q <= 1'b0;
    end else if (take) begin
      programmed_q <= 1'b1;
    end
  end

  assign programmed = programmed_q;

endmodule

//--- src/osc_mode_decode.sv
// Purpose: oscillator-type field to mode flags
// Assumes: purely combinational, registered by the caller
// Notes: none
`timescale 1ns/1ns
module osc_mode_decode
  import osc_config_pkg::*;
(
  // field in
  input wire logic [1:0] osc_type,
  // mode flags out
  output osc_mode_t mode,
  output logic external_clock_mode,
  output logic high_speed_crystal_mode,
  output logic pll_available,
  output logic clock_out_function
);

  assign mode = osc_mode_t'(osc_type);

  // code 00 is treated as a plain crystal: all flags low
  assign external_clock_mode = (mode == OSC_EXTERNAL_CLOCK_PLL) ||
                               (mode == OSC_EXTERNAL_CLOCK);
  assign high_speed_crystal_mode = (mode == OSC_HIGH_SPEED_CRYSTAL);
  assign pll_available = (mode == OSC_EXTERNAL_CLOCK_PLL) ||
                         (mode == OSC_HIGH_SPEED_CRYSTAL);
  assign clock_out_function = (mode == OSC_EXTERNAL_CLOCK_PLL) ||
                              (mode == OSC_EXTERNAL_CLOCK);

endmodule

//--- src/oscillator_config_decode.sv
// Purpose: holds the clock configuration byte and decodes it for the
//          clock logic
// Assumes: register port strobes are one cycle, synchronous to SYS_CLK
// Notes: reset restores the unprogrammed byte; clock switching, the
//        start-up and monitor machinery and the PLL sit outside;
//        decoded outputs lag the stored byte by one cycle, while status
//        bits and the pin input are read without that delay
`timescale 1ns/1ns
`include "osc_config_defines.svh"
module oscillator_config_decode
  import osc_config_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [`OCD_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // start-up and monitor enables
  output logic DUAL_SPEED_STARTUP_EN,
  output logic FAILSAFE_MONITOR_EN,
  // system clock choice
  output logic USE_PRIMARY_OSC,
  output logic USE_INTERNAL_RC_OSC,
  output logic [1:0] RUNTIME_CLOCK_SELECT,
  // oscillator mode
  output logic [1:0] OSCILLATOR_TYPE,
  output logic EXTERNAL_CLOCK_MODE,
  output logic HIGH_SPEED_CRYSTAL_MODE,
  output logic PLL_AVAILABLE,
  output logic CLOCK_OUT_FUNCTION,
  // clock-out source from the clock logic
  input wire logic CLOCK_OUT_SRC,
  // second oscillator pin
  input wire logic SECOND_OSC_PIN_I,
  output logic SECOND_OSC_PIN_O,
  output logic SECOND_OSC_PIN_OE_N
);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // decoded outputs reset to what the erased byte decodes to, so they
  // never jump at the first edge after reset
  localparam logic [7:0] ERASED = `OCD_UNPROGRAMMED;
  localparam logic [1:0] ERASED_TYPE = ERASED[1:0];
  localparam logic ERASED_DUAL = ERASED[`OCD_BIT_DUAL_SPEED];
  localparam logic ERASED_FAILSAFE = ERASED[`OCD_BIT_FAILSAFE];
  localparam logic ERASED_DEFAULT = ERASED[`OCD_BIT_DEFAULT_SEL];
  localparam logic ERASED_RT_DEFAULT = (`OCD_RUNTIME_SELECT_RST == 2'h0);
  localparam logic ERASED_PRIMARY = ERASED_RT_DEFAULT & ERASED_DEFAULT;
  localparam logic ERASED_RC = ERASED_RT_DEFAULT & ~ERASED_DEFAULT;
  localparam logic ERASED_EXT = (ERASED_TYPE == OSC_EXTERNAL_CLOCK_PLL) ||
                                (ERASED_TYPE == OSC_EXTERNAL_CLOCK);
  localparam logic ERASED_HS = (ERASED_TYPE == OSC_HIGH_SPEED_CRYSTAL);
  localparam logic ERASED_PLL = (ERASED_TYPE == OSC_EXTERNAL_CLOCK_PLL) ||
                                (ERASED_TYPE == OSC_HIGH_SPEED_CRYSTAL);
  localparam logic ERASED_CLK_OUT = ERASED_EXT;
  // the pin stays released in reset whatever the erased mode says
  localparam logic PIN_O_RST = 1'b0;
  localparam logic PIN_OE_N_RST = 1'b1;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic sel_cfg = (ADDR == `OCD_OFS_CLOCK_CONFIG_LOW);
  wire logic sel_rt = (ADDR == `OCD_OFS_RUNTIME_SELECT);
  wire logic sel_stat = (ADDR == `OCD_OFS_STATUS);
  wire logic wr_cfg = WR & sel_cfg;
  wire logic wr_rt = WR & sel_rt;

  // ----------------------------------------------------------------
  // configuration byte
  // ----------------------------------------------------------------
  logic [7:0] cfg_value;
  logic cfg_programmed;

  // write-once storage; the byte is not writable again until reset
  write_once_byte #(
    .WIDTH(8),
    .IMPL_MASK(`OCD_IMPL_MASK)
  ) u_cfg (
    .clk(SYS_CLK),
    .rst(RST),
    .wr_en(wr_cfg),
    .wdata(WDATA),
    .value(cfg_value),
    .programmed(cfg_programmed)
  );

  // ----------------------------------------------------------------
  // run-time clock select
  // ----------------------------------------------------------------
  logic [1:0] rt_sel_q;
  // writes land at the strobe edge; the select has no read-back delay
  wire logic [1:0] rt_sel_d = wr_rt ? WDATA[1:0] : rt_sel_q;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rt_sel_q <= `OCD_RUNTIME_SELECT_RST;
    end else begin
      rt_sel_q <= rt_sel_d;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire logic dual_speed = cfg_value[`OCD_BIT_DUAL_SPEED];
  wire logic failsafe = cfg_value[`OCD_BIT_FAILSAFE];
  wire logic default_sel = cfg_value[`OCD_BIT_DEFAULT_SEL];
  wire logic [1:0] osc_type = cfg_value[1:0];
  wire logic rt_is_default = (rt_sel_q == 2'h0);

  // only the default selection is decided here; other codes belong to
  // the clock switch, which reads RUNTIME_CLOCK_SELECT itself
  wire logic use_primary = rt_is_default & default_sel;
  wire logic use_rc = rt_is_default & ~default_sel;

  // ----------------------------------------------------------------
  // oscillator mode decode
  // ----------------------------------------------------------------
  osc_mode_t mode;
  logic ext_clk;
  logic hs_xtal;
  logic pll_av;
  logic clk_out;

  // code 00 decodes as a plain crystal with every flag low
  osc_mode_decode u_mode (
    .osc_type(osc_type),
    .mode(mode),
    .external_clock_mode(ext_clk),
    .high_speed_crystal_mode(hs_xtal),
    .pll_available(pll_av),
    .clock_out_function(clk_out)
  );

  // ----------------------------------------------------------------
  // registered decode outputs
  // ----------------------------------------------------------------
  logic dual_speed_q;
  logic failsafe_q;
  logic use_primary_q;
  logic use_rc_q;
  osc_mode_t mode_q;
  logic ext_clk_q;
  logic hs_xtal_q;
  logic pll_av_q;
  logic clk_out_q;

  // one block per output keeps each reset value beside its register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dual_speed_q <= ERASED_DUAL;
    end else begin
      dual_speed_q <= dual_speed;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      failsafe_q <= ERASED_FAILSAFE;
    end else begin
      failsafe_q <= failsafe;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      use_primary_q <= ERASED_PRIMARY;
    end else begin
      use_primary_q <= use_primary;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      use_rc_q <= ERASED_RC;
    end else begin
      use_rc_q <= use_rc;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mode_q <= osc_mode_t'(ERASED_TYPE);
    end else begin
      mode_q <= mode;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ext_clk_q <= ERASED_EXT;
    end else begin
      ext_clk_q <= ext_clk;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hs_xtal_q <= ERASED_HS;
    end else begin
      hs_xtal_q <= hs_xtal;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pll_av_q <= ERASED_PLL;
    end else begin
      pll_av_q <= pll_av;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      clk_out_q <= ERASED_CLK_OUT;
    end else begin
      clk_out_q <= clk_out;
    end
  end

  // ----------------------------------------------------------------
  // second oscillator pin
  // ----------------------------------------------------------------
  logic pin_o_q;
  logic pin_oe_n_q;
  // one cycle of latency on the clock-out; the pin stays released in
  // crystal modes so the crystal can use it
  wire logic pin_o_d = clk_out & CLOCK_OUT_SRC;
  wire logic pin_oe_n_d = ~clk_out;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_o_q <= PIN_O_RST;
    end else begin
      pin_o_q <= pin_o_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_oe_n_q <= PIN_OE_N_RST;
    end else begin
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // status shows the clock choice before its one-cycle register
  logic [7:0] status_word;
  assign status_word[0] = cfg_programmed;
  assign status_word[1] = 1'b0;
  assign status_word[2] = use_rc;
  assign status_word[3] = use_primary;
  assign status_word[4] = SECOND_OSC_PIN_I;
  assign status_word[7:5] = 3'h0;

  wire logic [7:0] cfg_word = cfg_value & `OCD_IMPL_MASK;
  wire logic [7:0] rt_word = {6'h00, rt_sel_q};
  // unmapped offsets read as zero
  wire logic [7:0] rd_mux = sel_cfg ? cfg_word :
                            sel_rt ? rt_word :
                            sel_stat ? status_word : 8'h00;
  // data stand only in the cycle after the strobe
  wire logic [7:0] rdata_d = RD ? rd_mux : 8'h00;

  logic [7:0] rdata_q;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA = rdata_q;
  assign DUAL_SPEED_STARTUP_EN = dual_speed_q;
  assign FAILSAFE_MONITOR_EN = failsafe_q;
  assign USE_PRIMARY_OSC = use_primary_q;
  assign USE_INTERNAL_RC_OSC = use_rc_q;
  assign RUNTIME_CLOCK_SELECT = rt_sel_q;
  assign OSCILLATOR_TYPE = mode_q;
  assign EXTERNAL_CLOCK_MODE = ext_clk_q;
  assign HIGH_SPEED_CRYSTAL_MODE = hs_xtal_q;
  assign PLL_AVAILABLE = pll_av_q;
  assign CLOCK_OUT_FUNCTION = clk_out_q;
  assign SECOND_OSC_PIN_O = pin_o_q;
  assign SECOND_OSC_PIN_OE_N = pin_oe_n_q;

endmodule

//--- verif/osc_config_checker.sv
// Purpose: port-level assertions for the oscillator configuration decoder
// Assumes: one clock, synchronous active-high reset
// Notes: register-port rules are judged against the decoded outputs
`timescale 1ns/1ns
`include "osc_config_defines.svh"
module osc_config_checker (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [`OCD_ADDR_W-1:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // decoded outputs
  input wire logic DUAL_SPEED_STARTUP_EN,
  input wire logic FAILSAFE_MONITOR_EN,
  input wire logic USE_PRIMARY_OSC,
  input wire logic USE_INTERNAL_RC_OSC,
  input wire logic [1:0] RUNTIME_CLOCK_SELECT,
  input wire logic [1:0] OSCILLATOR_TYPE,
  input wire logic EXTERNAL_CLOCK_MODE,
  input wire logic HIGH_SPEED_CRYSTAL_MODE,
  input wire logic PLL_AVAILABLE,
  input wire logic CLOCK_OUT_FUNCTION,
  // pin
  input wire logic CLOCK_OUT_SRC,
  input wire logic SECOND_OSC_PIN_O,
  input wire logic SECOND_OSC_PIN_OE_N
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // both sides come from the same stored byte, so they must agree
  property p_rd_cfg;
    RD && ADDR == `OCD_OFS_CLOCK_CONFIG_LOW |=> RDATA[7] == DUAL_SPEED_STARTUP_EN &&
      RDATA[6] == FAILSAFE_MONITOR_EN && RDATA[5:3] == 3'h0 && RDATA[1:0] == OSCILLATOR_TYPE;
  endproperty
  a_rd_cfg: assert property (p_rd_cfg)
    else $error("config read disagrees with decoded outputs");
  property p_rd_idle;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read answer");
  property p_sel_zero;
    RUNTIME_CLOCK_SELECT == 2'h0 |=> USE_PRIMARY_OSC != USE_INTERNAL_RC_OSC;
  endproperty
  a_sel_zero: assert property (p_sel_zero)
    else $error("no single default clock with select zero");
  property p_sel_other;
    RUNTIME_CLOCK_SELECT != 2'h0 |=> !USE_PRIMARY_OSC && !USE_INTERNAL_RC_OSC;
  endproperty
  a_sel_other: assert property (p_sel_other)
    else $error("default clock claimed with select nonzero");
  property p_type3;
    OSCILLATOR_TYPE == 2'h3 |-> EXTERNAL_CLOCK_MODE && PLL_AVAILABLE &&
      CLOCK_OUT_FUNCTION && !HIGH_SPEED_CRYSTAL_MODE;
  endproperty
  a_type3: assert property (p_type3)
    else $error("type 3 flags wrong");
  property p_type2;
    OSCILLATOR_TYPE == 2'h2 |-> EXTERNAL_CLOCK_MODE && !PLL_AVAILABLE &&
      CLOCK_OUT_FUNCTION && !HIGH_SPEED_CRYSTAL_MODE;
  endproperty
  a_type2: assert property (p_type2)
    else $error("type 2 flags wrong");
  property p_type1;
    OSCILLATOR_TYPE == 2'h1 |-> !EXTERNAL_CLOCK_MODE && PLL_AVAILABLE &&
      !CLOCK_OUT_FUNCTION && HIGH_SPEED_CRYSTAL_MODE;
  endproperty
  a_type1: assert property (p_type1)
    else $error("type 1 flags wrong");
  property p_type0;
    OSCILLATOR_TYPE == 2'h0 |-> !EXTERNAL_CLOCK_MODE && !PLL_AVAILABLE &&
      !CLOCK_OUT_FUNCTION && !HIGH_SPEED_CRYSTAL_MODE;
  endproperty
  a_type0: assert property (p_type0)
    else $error("type 0 flags wrong");
  property p_pin_oe;
    !$past(RST) |-> SECOND_OSC_PIN_OE_N == !CLOCK_OUT_FUNCTION;
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin enable does not follow clock-out mode");
  property p_pin_o;
    !$past(RST) |-> SECOND_OSC_PIN_O == (CLOCK_OUT_FUNCTION && $past(CLOCK_OUT_SRC));
  endproperty
  a_pin_o: assert property (p_pin_o)
    else $error("pin level does not follow clock-out source");
endmodule

bind oscillator_config_decode osc_config_checker u_chk (.SYS_CLK, .RST, .ADDR, .RD, .RDATA,
  .DUAL_SPEED_STARTUP_EN, .FAILSAFE_MONITOR_EN, .USE_PRIMARY_OSC, .USE_INTERNAL_RC_OSC,
  .RUNTIME_CLOCK_SELECT, .OSCILLATOR_TYPE, .EXTERNAL_CLOCK_MODE, .HIGH_SPEED_CRYSTAL_MODE,
  .PLL_AVAILABLE, .CLOCK_OUT_FUNCTION, .CLOCK_OUT_SRC, .SECOND_OSC_PIN_O,
  .SECOND_OSC_PIN_OE_N);

//--- verif/oscillator_config_decode_tb_top.sv
// Purpose: register-level tests of the oscillator configuration decoder
// Assumes: 10 MHz clock, reset restores the unprogrammed byte
// Notes: each oscillator type needs its own reset, the byte locks after one write
`timescale 1ns/1ns
`include "osc_config_defines.svh"
module oscillator_config_decode_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [`OCD_ADDR_W-1:0] ADDR = '0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic CLOCK_OUT_SRC = 1'b0;
  logic pin_ext = 1'b0;
  logic [7:0] RDATA;
  logic DUAL_SPEED_STARTUP_EN, FAILSAFE_MONITOR_EN, USE_PRIMARY_OSC, USE_INTERNAL_RC_OSC;
  logic [1:0] RUNTIME_CLOCK_SELECT, OSCILLATOR_TYPE;
  logic EXTERNAL_CLOCK_MODE, HIGH_SPEED_CRYSTAL_MODE, PLL_AVAILABLE, CLOCK_OUT_FUNCTION;
  logic SECOND_OSC_PIN_O, SECOND_OSC_PIN_OE_N;
  wire logic SECOND_OSC_PIN_I;
  logic [7:0] rdv, dat;
  logic [1:0] ty;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // released pin shows the outside level, a driven pin its own level
  assign SECOND_OSC_PIN_I = SECOND_OSC_PIN_OE_N ? pin_ext : SECOND_OSC_PIN_O;

  oscillator_config_decode DUT (.SYS_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .DUAL_SPEED_STARTUP_EN, .FAILSAFE_MONITOR_EN, .USE_PRIMARY_OSC, .USE_INTERNAL_RC_OSC,
    .RUNTIME_CLOCK_SELECT, .OSCILLATOR_TYPE, .EXTERNAL_CLOCK_MODE, .HIGH_SPEED_CRYSTAL_MODE,
    .PLL_AVAILABLE, .CLOCK_OUT_FUNCTION, .CLOCK_OUT_SRC, .SECOND_OSC_PIN_I,
    .SECOND_OSC_PIN_O, .SECOND_OSC_PIN_OE_N);

  // ----------------------------------------------------------------
  // clock, source waveform, timeout
  // ----------------------------------------------------------------
  always #50 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) CLOCK_OUT_SRC <= ~CLOCK_OUT_SRC;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 rdv = RDATA;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(`OCD_OFS_CLOCK_CONFIG_LOW);
    chk("unprogrammed config", rdv, `OCD_UNPROGRAMMED);
    rd(`OCD_OFS_STATUS);
    chk("programmed flag", rdv[0], 1'b0);
    rd(4'hF);
    chk("unmapped read", rdv, 8'h00);
    $display("test reset values done");
    for (int t = 0; t < 4; t++) begin
      ty = t[1:0];
      dat = {ty[0], ty[1], 3'b111, ^ty, ty};
      @(posedge SYS_CLK);
      RST <= 1'b1;
      pin_ext <= ty[0];
      repeat (3) @(posedge SYS_CLK);
      RST <= 1'b0;
      wr(`OCD_OFS_CLOCK_CONFIG_LOW, dat);
      wr(`OCD_OFS_CLOCK_CONFIG_LOW, ~dat);
      rd(`OCD_OFS_CLOCK_CONFIG_LOW);
      chk("config readback", rdv, dat & 8'hC7);
      chk("dual speed", DUAL_SPEED_STARTUP_EN, ty[0]);
      chk("fail safe", FAILSAFE_MONITOR_EN, ty[1]);
      chk("use primary", USE_PRIMARY_OSC, ^ty);
      chk("use rc", USE_INTERNAL_RC_OSC, !(^ty));
      chk("osc type", OSCILLATOR_TYPE, ty);
      chk("external", EXTERNAL_CLOCK_MODE, ty[1]);
      chk("high speed", HIGH_SPEED_CRYSTAL_MODE, ty == 2'h1);
      chk("pll", PLL_AVAILABLE, ty[0]);
      chk("clock out", CLOCK_OUT_FUNCTION, ty[1]);
      chk("pin enable", SECOND_OSC_PIN_OE_N, !ty[1]);
      wr(`OCD_OFS_STATUS, 8'hFF);
      rd(`OCD_OFS_STATUS);
      chk("status", rdv & (ty[1] ? 8'hEF : 8'hFF), {3'h0, pin_ext & !ty[1], ^ty, !(^ty), 2'h1});
      wr(`OCD_OFS_RUNTIME_SELECT, {6'h3F, ty});
      rd(`OCD_OFS_RUNTIME_SELECT);
      chk("select readback", rdv, {6'h00, ty});
      chk("select out", RUNTIME_CLOCK_SELECT, ty);
      chk("primary when switched", USE_PRIMARY_OSC, 1'b0);
      chk("rc when switched", USE_INTERNAL_RC_OSC, ty == 2'h0);
      $display("test type %0d done", t);
    end
    test_done();
  end
endmodule
